// >>> verilog/asp_pkg.sv
package asp_pkg;
  // register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_OFFSET = 8'h04;
  localparam logic [7:0] REG_CLOCK  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // control register fields
  localparam int FMT_LSB         = 0;
  localparam int WL_LSB          = 4;
  localparam int BIT_WCLK_MASTER = 6;
  localparam int BIT_BCLK_MASTER = 7;
  localparam int BIT_BCLK_INV    = 8;
  localparam int BIT_TRISTATE    = 9;
  localparam int BIT_EARLY_TRI   = 10;
  localparam int BIT_SLOT_MODE   = 11;
  localparam int BIT_SWAP        = 12;
  localparam int BIT_FIRST_OFF   = 13;
  localparam int BIT_SECOND_OFF  = 14;
  localparam int BIT_WCLK_PULSE  = 15;
  localparam int BIT_PORT_POWER  = 16;
  localparam int BIT_KEEP_CLOCKS = 17;

  // offset, clock and status register fields
  localparam int FIRST_OFFSET_LSB = 0;
  localparam int SECOND_GAP_LSB   = 8;
  localparam int DIV_LSB          = 0;
  localparam int FRAME_BITS_LSB   = 16;
  localparam int COUNT_LSB        = 16;

  // interface formats
  localparam logic [2:0] FMT_I2S   = 3'h0;
  localparam logic [2:0] FMT_DSP   = 3'h1;
  localparam logic [2:0] FMT_RIGHT = 3'h2;
  localparam logic [2:0] FMT_LEFT  = 3'h3;
  localparam logic [2:0] FMT_TDM   = 3'h4;

  // reset values and writable bits
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] OFFSET_RESET = 32'h0000_0000;
  localparam logic [31:0] CLOCK_RESET  = 32'h0040_0004;
  localparam logic [31:0] CTRL_MASK    = 32'h0003_FFF7;
  localparam logic [31:0] OFFSET_MASK  = 32'h0000_FFFF;
  localparam logic [31:0] CLOCK_MASK   = 32'h01FF_00FF;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// >>> verilog/audio_serial_port.sv
// Contract
// - samples go MSB first, 16/20/24/32 bits
// - I2S, left, right, DSP, TDM framing
// - word and bit clock master or slave
// - word clock marks frame, pulse or square
// - master bit clock from programmable divider
// - without slots both channels share first offset
// - slot mode: gap after first LSB
// - swap bit exchanges channel order
// - invert bit flips launch edge
// - tristate option releases output after LSB
// - early tristate releases half bit sooner
// - powered-down master port floats its pins
// - each channel can be disabled, except in right-aligned format
// - disabled channel drives low without tristate
// - filter sync at earlier enabled channel
// - both disabled: nothing on serial bus
// - master clocks gated unless converter powered or keep-clocks bit set
// - right-aligned LSB ends before word edge
// - left-aligned MSB right after word edge
// - I2S MSB on second bit after edge
// - DSP: left then right, falling-edge valid
// - slot mode ignores word clock fall
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module audio_serial_port (
  input  logic        ref_clk,
  input  logic        resetn,
  input  logic [7:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [7:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  input  logic [31:0] left_sample,
  input  logic [31:0] right_sample,
  input  logic        adc_powered,
  input  logic        bclk_in,
  output logic        bclk_out,
  output logic        bclk_oe,
  input  logic        wclk_in,
  output logic        wclk_out,
  output logic        wclk_oe,
  output logic        dout,
  output logic        dout_oe,
  output logic        filter_sync
);

  function automatic logic [5:0] word_bits(input logic [1:0] code);
    logic [5:0] n;
    unique case (code)
      2'h0: n = 6'h10;
      2'h1: n = 6'h14;
      2'h2: n = 6'h18;
      2'h3: n = 6'h20;
    endcase
    return n;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res & mask;
  endfunction

  logic [31:0] ctrl;
  logic [31:0] offs;
  logic [31:0] clkcfg;
  logic [15:0] frame_count;
  logic [7:0]  div_cnt;
  logic        bclk_prev;
  logic [8:0]  fpos;
  logic        frame_prev;
  logic [9:0]  cnt;
  logic        in_second;
  logic [31:0] shreg;
  logic [5:0]  bits_left;
  logic        active;
  logic        cur_en;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire [2:0] fmt         = ctrl[asp_pkg::FMT_LSB +: 3];
  wire [5:0] wl          = word_bits(ctrl[asp_pkg::WL_LSB +: 2]);
  wire       wclk_master = ctrl[asp_pkg::BIT_WCLK_MASTER];
  wire       bclk_master = ctrl[asp_pkg::BIT_BCLK_MASTER];
  wire       bclk_inv    = ctrl[asp_pkg::BIT_BCLK_INV];
  wire       tristate    = ctrl[asp_pkg::BIT_TRISTATE];
  wire       early       = ctrl[asp_pkg::BIT_EARLY_TRI];
  wire       slot_mode   = ctrl[asp_pkg::BIT_SLOT_MODE];
  wire       swap        = ctrl[asp_pkg::BIT_SWAP];
  wire       wclk_pulse  = ctrl[asp_pkg::BIT_WCLK_PULSE];
  wire       port_power  = ctrl[asp_pkg::BIT_PORT_POWER];
  wire       keep_clocks = ctrl[asp_pkg::BIT_KEEP_CLOCKS];
  wire [7:0] off1        = offs[asp_pkg::FIRST_OFFSET_LSB +: 8];
  wire [7:0] off2        = offs[asp_pkg::SECOND_GAP_LSB +: 8];
  wire [7:0] div         = clkcfg[asp_pkg::DIV_LSB +: 8];
  wire [8:0] frame_bits  = clkcfg[asp_pkg::FRAME_BITS_LSB +: 9];

  wire is_i2s   = fmt == asp_pkg::FMT_I2S;
  wire is_rj    = fmt == asp_pkg::FMT_RIGHT;
  wire dsp_like = (fmt == asp_pkg::FMT_DSP) || (fmt == asp_pkg::FMT_TDM);
  wire halves   = !slot_mode && !dsp_like;
  // right-aligned keeps both channels; the other formats honour the disables
  wire en_a     = !ctrl[asp_pkg::BIT_FIRST_OFF] || is_rj;
  wire en_b     = !ctrl[asp_pkg::BIT_SECOND_OFF] || is_rj;
  wire any_en   = en_a || en_b;
  wire run      = port_power && (adc_powered || keep_clocks);
  wire [7:0] div_max = (div == 8'h00) ? 8'h00 : div - 8'h01;

  // master bit clock: period of twice the divider in ref_clk cycles
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt  <= 8'h00;
      bclk_out <= 1'b0;
    end else if (!run || !bclk_master) begin
      div_cnt  <= 8'h00;
      bclk_out <= 1'b0;
    end else if (div_cnt >= div_max) begin
      div_cnt  <= 8'h00;
      bclk_out <= ~bclk_out;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bclk_oe <= 1'b0;
      wclk_oe <= 1'b0;
    end else begin
      bclk_oe <= bclk_master && port_power;
      wclk_oe <= wclk_master && port_power;
    end
  end

  // bit clock edges; data launch edge flips for DSP and for inversion
  wire bclk_lvl   = bclk_master ? bclk_out : bclk_in;
  wire launch_lvl = dsp_like ^ bclk_inv;
  wire edge_seen  = (bclk_lvl != bclk_prev) && port_power;
  wire launch_ev  = edge_seen && (bclk_lvl == launch_lvl);
  wire capture_ev = edge_seen && (bclk_lvl != launch_lvl);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bclk_prev <= 1'b0;
    end else begin
      bclk_prev <= bclk_lvl;
    end
  end

  // master word clock; I2S runs it inverted so left sits in the low half
  wire [8:0] next_fpos = (fpos >= frame_bits - 9'h001) ? 9'h000 : fpos + 9'h001;
  wire [8:0] high_len  = wclk_pulse ? 9'h001 : {1'b0, frame_bits[8:1]};
  wire       gen_frame = next_fpos < high_len;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fpos     <= 9'h000;
      wclk_out <= 1'b0;
    end else if (!run || !wclk_master) begin
      fpos     <= frame_bits - 9'h001;
      wclk_out <= is_i2s;
    end else if (launch_ev) begin
      fpos     <= next_fpos;
      wclk_out <= gen_frame ^ is_i2s;
    end
  end

  // frame position, counted in launch edges since the word clock edge
  wire frame_lvl  = wclk_master ? gen_frame : (wclk_in ^ is_i2s);
  wire rise       = launch_ev && frame_lvl && !frame_prev;
  wire fall       = launch_ev && !frame_lvl && frame_prev;
  wire restart    = rise || (fall && halves);
  wire second_now = (fall && halves) || (!rise && in_second);
  wire [9:0] pos  = restart ? 10'h000 : cnt + 10'h001;

  // standard MSB position plus the first offset
  wire [9:0] start1 = is_rj ? ({2'b00, frame_bits[8:1]} - {4'h0, wl} + {2'b00, off1})
                            : ({2'b00, off1} + {9'h000, is_i2s});
  wire [9:0] gap    = slot_mode ? {2'b00, off2} : 10'h000;
  wire [9:0] start2 = start1 + {4'h0, wl} + gap;

  wire first_start  = launch_ev && !second_now && (pos == start1);
  wire second_start = launch_ev && (halves ? (second_now && (pos == start1))
                                           : (!second_now && (pos == start2)));
  wire start_any    = first_start || second_start;
  wire chan_en      = first_start ? en_a : en_b;
  // samples are taken from the inputs at the channel's first bit
  wire [31:0] word_now = (first_start ^ swap) ? left_sample : right_sample;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_prev <= 1'b0;
      cnt        <= 10'h000;
      in_second  <= 1'b0;
    end else if (launch_ev) begin
      frame_prev <= frame_lvl;
      cnt        <= pos;
      in_second  <= second_now;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_count <= 16'h0000;
    end else if (rise) begin
      frame_count <= frame_count + 16'h0001;
    end
  end

  // serialiser and data pin enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shreg     <= 32'h0000_0000;
      bits_left <= 6'h00;
      active    <= 1'b0;
      cur_en    <= 1'b0;
      dout      <= 1'b0;
      dout_oe   <= 1'b0;
    end else if (!port_power || !any_en) begin
      active  <= 1'b0;
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else if (start_any) begin
      active    <= 1'b1;
      cur_en    <= chan_en;
      bits_left <= wl - 6'h01;
      shreg     <= {word_now[30:0], 1'b0};
      dout      <= chan_en & word_now[31];
      dout_oe   <= chan_en || !tristate;
    end else if (launch_ev && active && (bits_left != 6'h00)) begin
      bits_left <= bits_left - 6'h01;
      shreg     <= {shreg[30:0], 1'b0};
      dout      <= cur_en & shreg[31];
    end else if (launch_ev && active) begin
      active  <= 1'b0;
      dout    <= 1'b0;
      dout_oe <= !tristate;
    end else if (capture_ev && active && (bits_left == 6'h00) && tristate && early) begin
      dout_oe <= 1'b0;
    end else if (!active) begin
      dout_oe <= !tristate;
    end
  end

  // sync follows the earlier enabled channel, or the first when none is
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      filter_sync <= 1'b0;
    end else begin
      filter_sync <= (first_start && (en_a || !en_b)) || (second_start && !en_a && en_b);
    end
  end

  // AXI4-Lite write: one transfer at a time, address and data in either order
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= asp_pkg::RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr > asp_pkg::REG_STATUS) ? asp_pkg::RESP_DECERR
                                                        : asp_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl   <= asp_pkg::CTRL_RESET;
      offs   <= asp_pkg::OFFSET_RESET;
      clkcfg <= asp_pkg::CLOCK_RESET;
    end else if (wr_fire) begin
      case (aw_addr)
        asp_pkg::REG_CTRL:   ctrl   <= merge(ctrl, w_data, w_strb, asp_pkg::CTRL_MASK);
        asp_pkg::REG_OFFSET: offs   <= merge(offs, w_data, w_strb, asp_pkg::OFFSET_MASK);
        asp_pkg::REG_CLOCK:  clkcfg <= merge(clkcfg, w_data, w_strb, asp_pkg::CLOCK_MASK);
        default: ;
      endcase
    end
  end

  // AXI4-Lite read; status shows live serialiser and frame state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= asp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= asp_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        asp_pkg::REG_CTRL:   s_axi_rdata <= ctrl;
        asp_pkg::REG_OFFSET: s_axi_rdata <= offs;
        asp_pkg::REG_CLOCK:  s_axi_rdata <= clkcfg;
        asp_pkg::REG_STATUS: s_axi_rdata <= {frame_count, 14'h0000, frame_prev, active};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= asp_pkg::RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  bclk_div_a: assert property ($changed(bclk_out) && $past(run && bclk_master)
    |-> $past(div_cnt) == $past(div_max)) else $error("bit clock toggled off divider count");
  clk_gate_a: assert property (!run |=> !bclk_out)
    else $error("master bit clock ran while gated");
  pdown_hiz_a: assert property (!port_power |=> !bclk_oe && !wclk_oe && !dout_oe)
    else $error("pins driven while port powered down");
  msb_load_a: assert property (start_any && chan_en && any_en && port_power
    |=> dout == $past(word_now[31]) && bits_left == $past(wl) - 6'h01)
    else $error("channel did not start at its MSB");
  swap_order_a: assert property (first_start && swap && en_a && port_power
    |=> dout == $past(right_sample[31])) else $error("swap did not lead with right");
  lsb_release_a: assert property (launch_ev && active && bits_left == 6'h00
    && tristate && port_power && !start_any |=> !dout_oe)
    else $error("output not released after LSB");
  early_release_a: assert property (capture_ev && active && bits_left == 6'h00
    && tristate && early && port_power && !launch_ev |=> !dout_oe)
    else $error("early release missed");
  drive_low_a: assert property (start_any && !chan_en && !tristate && any_en
    && port_power |=> dout_oe && !dout ##1 !dout) else $error("disabled slot not driven low");
  none_out_a: assert property (!any_en |=> !dout_oe)
    else $error("data driven with both channels off");
  sync_cause_a: assert property (filter_sync |-> $past(start_any))
    else $error("filter sync without channel start");
  slot_fall_a: assert property (fall && slot_mode |=> cnt == $past(cnt) + 10'h001)
    else $error("slot mode restarted on falling word clock");

  first_chan_c: cover property (first_start && en_a);
  slot_second_c: cover property (second_start && slot_mode);
  early_tri_c: cover property (capture_ev && active && tristate && early);

endmodule

// >>> tb/host_port_model.sv
`timescale 1ns/1ns
module host_port_model #(
  parameter int HALF_NS = 20
) (
  input  wire logic        clk_on,
  input  wire logic        cap_fall,
  input  wire logic        bclk_pin,
  input  wire logic        wclk_pin,
  input  wire logic        dout_pin,
  input  wire logic        dout_oe,
  output logic             host_bclk,
  output logic             host_wclk,
  output logic [63:0]      snap_d,
  output logic [63:0]      snap_oe
);
  logic [63:0] cur_d;
  logic [63:0] cur_oe;
  logic [5:0]  hpos;
  logic [5:0]  idx;
  logic        prev_w;

  initial begin
    host_bclk = 1'b0;
    host_wclk = 1'b0;
    hpos = 6'h00;
    idx = 6'h00;
    prev_w = 1'b0;
    cur_d = '0;
    cur_oe = '0;
    snap_d = '0;
    snap_oe = '0;
  end

  // bit clock rests low unless the device is slave
  // half period a whole number of ref periods, so pins move on its falling edge, never racing it
  always begin
    #HALF_NS;
    if (clk_on) begin
      host_bclk = ~host_bclk;
      if (!host_bclk) begin
        hpos = hpos + 6'h01;
        host_wclk = ~hpos[5];
      end
    end else begin
      host_bclk = 1'b0;
    end
  end

  // capture opposite the launch edge; a seen word clock rise restarts the frame
  always @(bclk_pin) begin
    if (bclk_pin !== cap_fall) begin
      idx = (wclk_pin && !prev_w) ? 6'h00 : idx + 6'h01;
      prev_w = wclk_pin;
      if (idx == 6'h00) begin
        snap_d = cur_d;
        snap_oe = cur_oe;
      end
      cur_d[idx] = dout_pin;
      cur_oe[idx] = dout_oe;
    end
  end
endmodule

// >>> tb/audio_serial_port_tb.sv
`timescale 1ns/1ns
module audio_serial_port_tb;
  logic        ref_clk, resetn, adc_powered, clk_on, cap_fall;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, left_sample, right_sample, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        bclk_in, bclk_out, bclk_oe, wclk_in, wclk_out, wclk_oe;
  logic        dout, dout_oe, filter_sync, host_bclk, host_wclk;
  logic [63:0] snap_d, snap_oe;
  int          n_fail, n_compared, t;

  localparam int NC = 13;
  logic [31:0] c_ctrl [NC] = '{
    32'h0001_00C3,
    32'h0001_10C3,
    32'h0001_00C0,
    32'h0001_00C2,
    32'h0001_00C1,
    32'h0001_08C3,
    32'h0001_01C3,
    32'h0001_00E3,
    32'h0001_22C3,
    32'h0001_40C3,
    32'h0001_60C3,
    32'h0001_0003,
    32'h0001_8EC4
  };
  logic [15:0] c_off [NC] = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h100,
                              16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h100};
  int          c_il [NC] = '{0, 33, 33, 16, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  int          c_ir [NC] = '{32, 1, 1, 48, 16, 17, 32, 32, 32, 32, 32, 32, 17};

  // shared pins: whoever enables drives
  assign bclk_in = bclk_oe ? bclk_out : host_bclk;
  assign wclk_in = wclk_oe ? wclk_out : host_wclk;

  audio_serial_port dut (
    .ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .left_sample, .right_sample,
    .adc_powered, .bclk_in, .bclk_out, .bclk_oe, .wclk_in, .wclk_out, .wclk_oe,
    .dout, .dout_oe, .filter_sync
  );

  host_port_model host (
    .clk_on, .cap_fall, .bclk_pin(bclk_in), .wclk_pin(wclk_in),
    .dout_pin(dout_oe ? dout : ~dout), .dout_oe, .host_bclk, .host_wclk, .snap_d, .snap_oe
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // md: 0 sample, 1 driven low, 2 released
  task automatic chk_ch(input string nm, input int i, input int wl, input int md,
                        input logic trist, input logic [31:0] s);
    logic [31:0] gd;
    logic [31:0] go;
    logic [31:0] m;
    gd = '0;
    go = '0;
    m = 32'hFFFF_FFFF << (32 - wl);
    for (int k = 0; k < wl; k++) begin
      gd[31 - k] = snap_d[(i + k) % 64];
      go[31 - k] = snap_oe[(i + k) % 64];
    end
    if (md != 2) chk({nm, " data"}, (md == 0) ? (s & m) : 32'h0, gd);
    chk({nm, " drive"}, (md == 2) ? 32'h0 : m, go);
    if (md == 0 && trist) chk({nm, " release"}, 32'h0, 32'(snap_oe[(i + wl) % 64]));
  endtask

  task automatic run_case(input logic [31:0] ct, input logic [15:0] of, input int il,
                          input int ir);
    int wl;
    int lm;
    int rm;
    logic sf;
    wl = (ct[5:4] == 2'h3) ? 32 : 16 + 4 * int'(ct[5:4]);
    // sync rides the first channel unless only the second is on
    sf = !ct[13] || ct[14];
    lm = (ct[14:13] == 2'h3) ? 2 : ct[13] ? (ct[9] ? 2 : 1) : 0;
    rm = (ct[14:13] == 2'h3) ? 2 : ct[14] ? (ct[9] ? 2 : 1) : 0;
    clk_on <= ~ct[asp_pkg::BIT_BCLK_MASTER];
    cap_fall <= ((ct[2:0] == asp_pkg::FMT_DSP) || (ct[2:0] == asp_pkg::FMT_TDM))
                ^ ct[asp_pkg::BIT_BCLK_INV];
    wr(asp_pkg::REG_OFFSET, {16'h0, of});
    wr(asp_pkg::REG_CTRL, ct);
    repeat (2200) @(posedge ref_clk);
    chk_ch("left", il, wl, lm, ct[asp_pkg::BIT_TRISTATE], left_sample);
    chk_ch("right", ir, wl, rm, ct[asp_pkg::BIT_TRISTATE], right_sample);
    @(posedge ref_clk iff filter_sync === 1'b1);
    chk("sync msb", (sf && ct[13]) ? 32'h0
        : 32'((sf ^ ct[12]) ? left_sample[31] : right_sample[31]), 32'(dout));
    $display("test frame %h done", ct);
  endtask

  task automatic count_toggles(output int n);
    logic p;
    n = 0;
    repeat (16) @(posedge ref_clk);
    p = bclk_out;
    repeat (64) begin
      @(posedge ref_clk);
      if (bclk_out !== p) n++;
      p = bclk_out;
    end
  endtask

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    test_done;
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    left_sample = 32'hA5C3_96F1;
    right_sample = 32'h3C5A_E18B;
    adc_powered = 1'b1;
    clk_on = 1'b0;
    cap_fall = 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rdr(asp_pkg::REG_CTRL);
    chk("ctrl reset", asp_pkg::CTRL_RESET, rd);
    rdr(asp_pkg::REG_CLOCK);
    chk("clock reset", asp_pkg::CLOCK_RESET, rd);
    wr(asp_pkg::REG_OFFSET, 32'hFFFF_FFFF);
    rdr(asp_pkg::REG_OFFSET);
    chk("offset mask", asp_pkg::OFFSET_MASK, rd);
    rdr(8'h10);
    chk("unmapped rresp", 32'(asp_pkg::RESP_DECERR), 32'(resp));
    wr(8'h10, 32'h1);
    chk("unmapped bresp", 32'(asp_pkg::RESP_DECERR), 32'(resp));
    $display("test registers done");
    for (int c = 0; c < NC; c++) begin
      run_case(c_ctrl[c], c_off[c], c_il[c], c_ir[c]);
    end
    adc_powered <= 1'b0;
    clk_on <= 1'b0;
    wr(asp_pkg::REG_CTRL, 32'h0001_00C3);
    count_toggles(t);
    chk("gated clock", 32'h0, 32'(t));
    wr(asp_pkg::REG_CTRL, 32'h0003_00C3);
    count_toggles(t);
    chk("kept clock", 32'h10, 32'(t));
    // divider changed only while gated, so no toggle lands off its count
    wr(asp_pkg::REG_CTRL, 32'h0001_00C3);
    wr(asp_pkg::REG_CLOCK, 32'h0040_0002);
    wr(asp_pkg::REG_CTRL, 32'h0003_00C3);
    count_toggles(t);
    chk("divided clock", 32'h20, 32'(t));
    wr(asp_pkg::REG_CTRL, 32'h0002_00C3);
    repeat (8) @(posedge ref_clk);
    chk("pins released", 32'h0, 32'({bclk_oe, wclk_oe, dout_oe}));
    $display("test clocks done");
    test_done;
  end
endmodule
